// file: design/pbcs_top.sv
// command and status logic of the host to pci bridge
`timescale 1ns/10ps
module pbcs_top
	import pbcs_pkg::*;
#(
	parameter logic [7:0] interface_revision = 8'h03
)
(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset,
	// configuration access
	input  wire logic          cfg_valid,
	input  wire logic          cfg_write,
	input  wire logic [7:0]    cfg_addr,
	input  wire logic [3:0]    cfg_byte_en,
	input  wire logic [31:0]   cfg_wdata,
	output logic               cfg_rvalid,
	output logic [31:0]        cfg_rdata,
	// pci target side
	input  wire pbcs_tgt_req_t tgt_req,
	output logic               tgt_claim,
	output pbcs_fwd_t          fwd,
	// pci master side
	input  wire pbcs_mst_req_t mst_req,
	input  wire logic          data_phase_ack,
	input  wire logic          lat_timer_expired,
	output logic               mst_start,
	output logic               mst_refused,
	output logic [3:0]         mst_cmd,
	output logic               burst_active,
	output logic               burst_stop,
	output logic               back_to_back_issue,
	output logic               stepping,
	// parity and read return
	input  wire pbcs_rd_in_t   rd_in,
	input  wire logic          par_err_master_write,
	input  wire logic          par_err_other,
	output pbcs_rd_out_t       rd_out,
	output logic               pci_error_irq,
	// system error pin, open drain
	input  wire logic          fatal_error,
	output logic               system_error_pin_level,
	output logic               system_error_pin_drive
);

	typedef enum logic [0:0] {
		PBCS_ST_IDLE  = 1'b0,
		PBCS_ST_BURST = 1'b1
	} pbcs_state_t;

	localparam logic mem_rst = (interface_revision >= PBCS_REV_NEW_DEFAULTS) ?
		PBCS_MEM_RST_NEW : PBCS_MEM_RST_OLD;

	// low bits of a word address fall on a line boundary
	function automatic logic line_aligned(input logic [29:0] word_addr,
		input logic [7:0] line);
		line_aligned = ((word_addr[7:0] & (line - 8'h01)) == 8'h00);
	endfunction

	// command and status storage
	logic        memory_decode_allow_reg;
	logic        bus_initiator_allow_reg;
	logic        write_invalidate_allow_reg;
	logic        parity_response_allow_reg;
	logic        system_error_drive_allow_reg;
	logic        initiator_data_parity_flag_reg;
	logic        any_parity_detected_flag_reg;
	logic [7:0]  line_size_words_reg;
	logic        initiator_data_parity_flag_next;
	logic        any_parity_detected_flag_next;

	// burst tracking
	pbcs_state_t state_reg;
	pbcs_state_t state_next;
	logic        wi_active_reg;
	logic        expired_seen_reg;
	logic [29:0] cur_word_reg;
	logic [15:0] words_left_reg;

	// register decode
	wire         sel_cmd_stat = cfg_valid && (cfg_addr == PBCS_OFF_CMD_STAT);
	wire         sel_line     = cfg_valid && (cfg_addr == PBCS_OFF_LINE_SIZE);
	wire         wr_cmd_lo    = sel_cmd_stat && cfg_write && cfg_byte_en[0];
	wire         wr_cmd_hi    = sel_cmd_stat && cfg_write && cfg_byte_en[1];
	wire         wr_stat_hi   = sel_cmd_stat && cfg_write && cfg_byte_en[3];
	wire         wr_line      = sel_line && cfg_write && cfg_byte_en[0];
	wire         clr_mdpe     = wr_stat_hi &&
		cfg_wdata[PBCS_STAT_SHIFT + PBCS_STAT_MDPE_BIT];
	wire         clr_dpe      = wr_stat_hi &&
		cfg_wdata[PBCS_STAT_SHIFT + PBCS_STAT_DPE_BIT];

	// read-only bits held at their fixed values
	wire [15:0]  command_half = {
		6'h00,
		1'b0,
		system_error_drive_allow_reg,
		1'b0,
		parity_response_allow_reg,
		1'b0,
		write_invalidate_allow_reg,
		1'b0,
		bus_initiator_allow_reg,
		memory_decode_allow_reg,
		1'b0
	};
	wire [15:0]  status_half = {
		any_parity_detected_flag_reg,
		4'h0,
		PBCS_DECODE_SPEED,
		initiator_data_parity_flag_reg,
		PBCS_B2B_ACCEPT,
		1'b0,
		PBCS_HIGH_SPEED,
		PBCS_CAP_LIST,
		4'h0
	};
	wire [31:0]  rdata_next = sel_cmd_stat ? {status_half, command_half} :
		sel_line ? {24'h00_0000, line_size_words_reg} : 32'h0000_0000;

	// parity events
	wire         master_par_err = (rd_in.valid && rd_in.par_err) || par_err_master_write;
	wire         any_par_err    = master_par_err || par_err_other;
	wire         mdpe_set       = master_par_err && parity_response_allow_reg;
	assign initiator_data_parity_flag_next = mdpe_set ||
		(initiator_data_parity_flag_reg && !clr_mdpe);
	assign any_parity_detected_flag_next = any_par_err ||
		(any_parity_detected_flag_reg && !clr_dpe);

	// target claim
	wire         claim_next = tgt_req.valid && (tgt_req.space == PBCS_SPACE_MEM) &&
		memory_decode_allow_reg;

	// master command choice
	wire [15:0]  line16      = {8'h00, line_size_words_reg};
	wire [15:0]  two_lines   = {7'h00, line_size_words_reg, 1'b0};
	wire         line_set    = (line_size_words_reg != 8'h00);
	wire [29:0]  start_word  = mst_req.addr[31:2];
	wire         start_align = line_aligned(start_word, line_size_words_reg);
	wire         full_line   = line_set && (mst_req.words >= line16);
	wire         use_wi      = mst_req.write && write_invalidate_allow_reg &&
		start_align && full_line;
	wire         take_req    = mst_req.valid && (state_reg == PBCS_ST_IDLE) &&
		bus_initiator_allow_reg && (mst_req.words != 16'h0000);
	wire         refuse_req  = mst_req.valid && !take_req;
	wire [3:0]   cmd_choice  =
		use_wi ? PBCS_CMD_WRITE_INV :
		mst_req.write ? PBCS_CMD_MEM_WRITE :
		(line_set && (mst_req.words >= two_lines)) ? PBCS_CMD_READ_MULTI :
		full_line ? PBCS_CMD_READ_LINE : PBCS_CMD_MEM_READ;

	// burst end
	wire [29:0]  next_word   = cur_word_reg + 30'h0000_0001;
	wire         expired_now = expired_seen_reg || lat_timer_expired;
	wire         at_boundary = line_aligned(next_word, line_size_words_reg);
	wire         timer_end   = expired_now &&
		(!wi_active_reg || at_boundary);
	wire         last_word   = (words_left_reg == 16'h0001);
	wire         end_burst   = (state_reg == PBCS_ST_BURST) && data_phase_ack &&
		(last_word || timer_end);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			PBCS_ST_IDLE:
			begin
				if (take_req)
					state_next = PBCS_ST_BURST;
			end
			PBCS_ST_BURST:
			begin
				if (end_burst)
					state_next = PBCS_ST_IDLE;
			end
		endcase
	end

	// configuration bits
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			memory_decode_allow_reg      <= mem_rst;
			bus_initiator_allow_reg      <= PBCS_RW_BIT_RST;
			write_invalidate_allow_reg   <= PBCS_RW_BIT_RST;
			parity_response_allow_reg    <= PBCS_RW_BIT_RST;
			system_error_drive_allow_reg <= PBCS_RW_BIT_RST;
			line_size_words_reg          <= PBCS_LINE_SIZE_RST;
		end
		else
		begin
			if (wr_cmd_lo)
			begin
				memory_decode_allow_reg    <= cfg_wdata[PBCS_CMD_MEM_BIT];
				bus_initiator_allow_reg    <= cfg_wdata[PBCS_CMD_MASTER_BIT];
				write_invalidate_allow_reg <= cfg_wdata[PBCS_CMD_WI_BIT];
				parity_response_allow_reg  <= cfg_wdata[PBCS_CMD_PAR_BIT];
			end
			if (wr_cmd_hi)
				system_error_drive_allow_reg <= cfg_wdata[PBCS_CMD_SERR_BIT];
			if (wr_line)
				line_size_words_reg <= cfg_wdata[7:0];
		end
	end

	// status flags, interrupt and read port
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			initiator_data_parity_flag_reg <= PBCS_FLAG_RST;
			any_parity_detected_flag_reg   <= PBCS_FLAG_RST;
			pci_error_irq                  <= PBCS_FLAG_RST;
			cfg_rvalid                     <= 1'b0;
			cfg_rdata                      <= 32'h0000_0000;
		end
		else
		begin
			initiator_data_parity_flag_reg <= initiator_data_parity_flag_next;
			any_parity_detected_flag_reg   <= any_parity_detected_flag_next;
			pci_error_irq                  <= initiator_data_parity_flag_next;
			cfg_rvalid                     <= cfg_valid && !cfg_write;
			cfg_rdata                      <= (cfg_valid && !cfg_write) ? rdata_next :
				32'h0000_0000;
		end
	end

	// target claim and forwarding
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			tgt_claim <= 1'b0;
			fwd       <= '0;
		end
		else
		begin
			tgt_claim  <= claim_next;
			fwd.valid  <= claim_next;
			fwd.write  <= tgt_req.write;
			fwd.addr   <= tgt_req.addr;
		end
	end

	// read data return
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			rd_out <= '0;
		else
		begin
			rd_out.valid   <= rd_in.valid;
			rd_out.data    <= rd_in.data;
			rd_out.bus_err <= rd_in.valid && rd_in.par_err &&
				parity_response_allow_reg;
		end
	end

	// master start and burst tracking
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_reg        <= PBCS_ST_IDLE;
			mst_start        <= 1'b0;
			mst_refused      <= 1'b0;
			mst_cmd          <= PBCS_CMD_MEM_READ;
			wi_active_reg    <= 1'b0;
			expired_seen_reg <= 1'b0;
			cur_word_reg     <= 30'h0000_0000;
			words_left_reg   <= 16'h0000;
			burst_active     <= 1'b0;
			burst_stop       <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			mst_start    <= take_req;
			mst_refused  <= refuse_req;
			burst_active <= (state_next == PBCS_ST_BURST);
			burst_stop   <= end_burst;
			if (take_req)
			begin
				mst_cmd          <= cmd_choice;
				wi_active_reg    <= use_wi;
				expired_seen_reg <= 1'b0;
				cur_word_reg     <= start_word;
				words_left_reg   <= mst_req.words;
			end
			else if (state_reg == PBCS_ST_BURST)
			begin
				if (lat_timer_expired)
					expired_seen_reg <= 1'b1;
				if (data_phase_ack)
				begin
					cur_word_reg   <= next_word;
					words_left_reg <= words_left_reg - 16'h0001;
				end
			end
		end
	end

	// never driven features and system error pin
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			back_to_back_issue     <= 1'b0;
			stepping               <= 1'b0;
			system_error_pin_level <= 1'b0;
			system_error_pin_drive <= 1'b0;
		end
		else
		begin
			back_to_back_issue     <= 1'b0;
			stepping               <= 1'b0;
			system_error_pin_level <= 1'b0;
			system_error_pin_drive <= fatal_error &&
				system_error_drive_allow_reg;
		end
	end

endmodule

// file: inc/pbcs_pkg.sv
// constants and carrier types for the bridge command and status block
// Summary of operation
// - io decode bit zero; never claim io
// - claim memory accesses only when enabled
// - memory enable resets per interface revision
// - master only while initiator bit set
// - ignore special cycles; bit reads zero
// - write invalidate only while enabled
// - write invalidate needs aligned full line
// - timer expiry ends invalidate at line boundary
// - no palette snoop; bit reads zero
// - parity response sets master flag, interrupt
// - detected parity flag set on every error
// - read parity error flagged when response on
// - no stepping; stepping bit reads zero
// - system error pin only while enabled
// - no back to back issue; bit zero
// - capability list flag reads zero
// - high speed flag reads one
// - back to back accept flag reads one
// - master parity flag needs response enabled
// - master flag holds interrupt; write one clears
// - decode speed code reads 01
// - line size register in 32-bit words
// - bit 15 any parity, write one clears
package pbcs_pkg;

	// register offsets
	localparam logic [7:0] PBCS_OFF_CMD_STAT  = 8'h04;
	localparam logic [7:0] PBCS_OFF_LINE_SIZE = 8'h0c;

	// command half field positions
	localparam int unsigned PBCS_CMD_IO_BIT     = 0;
	localparam int unsigned PBCS_CMD_MEM_BIT    = 1;
	localparam int unsigned PBCS_CMD_MASTER_BIT = 2;
	localparam int unsigned PBCS_CMD_WI_BIT     = 4;
	localparam int unsigned PBCS_CMD_PAR_BIT    = 6;
	localparam int unsigned PBCS_CMD_SERR_BIT   = 8;

	// status half field positions, within the upper half word
	localparam int unsigned PBCS_STAT_MDPE_BIT = 8;
	localparam int unsigned PBCS_STAT_DPE_BIT  = 15;
	localparam int unsigned PBCS_STAT_SHIFT    = 16;

	// reset and fixed values
	localparam logic [7:0] PBCS_REV_NEW_DEFAULTS = 8'h03;
	localparam logic       PBCS_MEM_RST_OLD      = 1'b1;
	localparam logic       PBCS_MEM_RST_NEW      = 1'b0;
	localparam logic       PBCS_RW_BIT_RST       = 1'b0;
	localparam logic       PBCS_FLAG_RST         = 1'b0;
	localparam logic [7:0] PBCS_LINE_SIZE_RST    = 8'h00;
	localparam logic [1:0] PBCS_DECODE_SPEED     = 2'h1;
	localparam logic       PBCS_HIGH_SPEED       = 1'b1;
	localparam logic       PBCS_B2B_ACCEPT       = 1'b1;
	localparam logic       PBCS_CAP_LIST         = 1'b0;

	typedef enum logic [1:0] {
		PBCS_SPACE_MEM     = 2'b00,
		PBCS_SPACE_IO      = 2'b01,
		PBCS_SPACE_SPECIAL = 2'b10,
		PBCS_SPACE_CONFIG  = 2'b11
	} pbcs_space_t;

	typedef enum logic [3:0] {
		PBCS_CMD_MEM_READ   = 4'b0110,
		PBCS_CMD_MEM_WRITE  = 4'b0111,
		PBCS_CMD_READ_MULTI = 4'b1100,
		PBCS_CMD_READ_LINE  = 4'b1110,
		PBCS_CMD_WRITE_INV  = 4'b1111
	} pbcs_bus_cmd_t;

	typedef struct packed {
		logic        valid;
		pbcs_space_t space;
		logic        write;
		logic [31:0] addr;
	} pbcs_tgt_req_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
	} pbcs_fwd_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [15:0] words;
	} pbcs_mst_req_t;

	typedef struct packed {
		logic        valid;
		logic        par_err;
		logic [31:0] data;
	} pbcs_rd_in_t;

	typedef struct packed {
		logic        valid;
		logic        bus_err;
		logic [31:0] data;
	} pbcs_rd_out_t;

endpackage

// file: dv/pbcs_props.sv
// port checker for the bridge command and status block
`timescale 1ns/10ps
module pbcs_props
	import pbcs_pkg::*;
(
	// clock and reset
	input wire logic          ref_clk,
	input wire logic          reset,
	// configuration access
	input wire logic          cfg_valid,
	input wire logic          cfg_write,
	// target side
	input wire pbcs_tgt_req_t tgt_req,
	input wire logic          tgt_claim,
	input wire pbcs_fwd_t     fwd,
	// master side
	input wire pbcs_mst_req_t mst_req,
	input wire logic          data_phase_ack,
	input wire logic          mst_start,
	input wire logic          mst_refused,
	input wire logic          burst_active,
	input wire logic          burst_stop,
	input wire logic          back_to_back_issue,
	input wire logic          stepping,
	// parity and errors
	input wire pbcs_rd_in_t   rd_in,
	input wire pbcs_rd_out_t  rd_out,
	input wire logic          pci_error_irq,
	input wire logic          fatal_error,
	input wire logic          system_error_pin_level,
	input wire logic          system_error_pin_drive
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	io_claim_block_a: assert property (
		tgt_req.valid && tgt_req.space != PBCS_SPACE_MEM |=> !tgt_claim)
		else $error("claim of a non memory access");
	claim_forward_a: assert property (
		tgt_claim |-> fwd.valid && $past(tgt_req.valid) && fwd.addr == $past(tgt_req.addr)
			&& fwd.write == $past(tgt_req.write))
		else $error("claim without matching forward");
	fixed_low_a: assert property (
		!back_to_back_issue && !stepping && !system_error_pin_level)
		else $error("fixed output not held low");
	serr_cause_a: assert property (
		system_error_pin_drive |-> $past(fatal_error))
		else $error("system error driven without fatal error");
	read_return_a: assert property (
		rd_in.valid |=> rd_out.valid && rd_out.data == $past(rd_in.data))
		else $error("read data not returned inward");
	error_irq_a: assert property (
		rd_out.bus_err |-> pci_error_irq)
		else $error("bus error without interrupt");
	irq_hold_a: assert property (
		pci_error_irq && !(cfg_valid && cfg_write) |=> pci_error_irq)
		else $error("interrupt dropped without clear");
	master_answer_a: assert property (
		mst_req.valid && !burst_active |=> mst_start != mst_refused)
		else $error("master request not answered once");
	stop_after_ack_a: assert property (
		burst_stop |-> !burst_active && $past(data_phase_ack))
		else $error("burst ended without data phase");
endmodule

bind pbcs_top pbcs_props u_props (.ref_clk, .reset, .cfg_valid, .cfg_write, .tgt_req,
	.tgt_claim, .fwd, .mst_req, .data_phase_ack, .mst_start, .mst_refused, .burst_active,
	.burst_stop, .back_to_back_issue, .stepping, .rd_in, .rd_out, .pci_error_irq,
	.fatal_error, .system_error_pin_level, .system_error_pin_drive);

// file: dv/pbcs_far_side.sv
// far side model: acknowledges data phases and returns read words
`timescale 1ns/10ps
module pbcs_far_side
	import pbcs_pkg::*;
(
	// clock and bridge view
	input  wire logic       ref_clk,
	input  wire logic       burst_active,
	input  wire logic [3:0] mst_cmd,
	// test controls
	input  wire logic       slow,
	input  wire logic       bad_parity,
	// bus answers
	output logic            data_phase_ack,
	output pbcs_rd_in_t     rd_in
);
	logic        hold_reg = 1'h0;
	logic [31:0] pat_reg = 32'h5a5a_0000;

	initial
	begin
		data_phase_ack = 1'h0;
		rd_in = '0;
	end
	// idle data lines carry the inverted pattern, never a stale word
	always @(posedge ref_clk)
	begin
		#1;
		hold_reg = slow && !hold_reg;
		data_phase_ack = burst_active && !hold_reg;
		pat_reg = pat_reg + 32'h0000_0001;
		rd_in.valid = data_phase_ack && !mst_cmd[0];
		rd_in.par_err = rd_in.valid && bad_parity;
		rd_in.data = rd_in.valid ? pat_reg : ~pat_reg;
	end
endmodule

// file: dv/tb.sv
// self-checking bench for the bridge command and status block
`timescale 1ns/10ps
module tb;
	import pbcs_pkg::*;
	logic          ref_clk = 1'h0;
	logic          reset = 1'h1;
	logic          cfg_valid = 1'h0;
	logic          cfg_write = 1'h0;
	logic [7:0]    cfg_addr = 8'h00;
	logic [3:0]    cfg_byte_en = 4'h0;
	logic [31:0]   cfg_wdata = 32'h0000_0000;
	pbcs_tgt_req_t tgt_req = '0;
	pbcs_mst_req_t mst_req = '0;
	logic          lat_timer_expired = 1'h0;
	logic          par_err_master_write = 1'h0;
	logic          par_err_other = 1'h0;
	logic          fatal_error = 1'h0;
	logic          slow = 1'h0;
	logic          bad_parity = 1'h0;
	logic          cfg_rvalid, tgt_claim, mst_start, mst_refused, burst_active, burst_stop;
	logic          back_to_back_issue, stepping, pci_error_irq, data_phase_ack;
	logic          system_error_pin_level, system_error_pin_drive, last_berr;
	logic [31:0]   cfg_rdata;
	logic [3:0]    mst_cmd;
	pbcs_fwd_t     fwd;
	pbcs_rd_in_t   rd_in;
	pbcs_rd_out_t  rd_out;
	int            err_count = 0;
	int            cmp_count = 0;
	int            acks_seen = 0;
	int            cycles = 0;
	logic [31:0]   mst_addr = 32'h0000_0100;

	pbcs_top u_dut (.ref_clk, .reset, .cfg_valid, .cfg_write, .cfg_addr, .cfg_byte_en,
		.cfg_wdata, .cfg_rvalid, .cfg_rdata, .tgt_req, .tgt_claim, .fwd, .mst_req,
		.data_phase_ack, .lat_timer_expired, .mst_start, .mst_refused, .mst_cmd,
		.burst_active, .burst_stop, .back_to_back_issue, .stepping, .rd_in,
		.par_err_master_write, .par_err_other, .rd_out, .pci_error_irq, .fatal_error,
		.system_error_pin_level, .system_error_pin_drive);
	pbcs_far_side u_far (.ref_clk, .burst_active, .mst_cmd, .slow, .bad_parity,
		.data_phase_ack, .rd_in);

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
		if (data_phase_ack && burst_active)
			acks_seen++;
	always @(rd_out)
		if (rd_out.valid)
			last_berr = rd_out.bus_err;
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			close_out;
		end
	end

	task automatic close_out;
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk(32'(got), 32'(exp));
	endtask
	task automatic cfg(input logic w, input logic [7:0] a);
		cfg_valid = 1'h1;
		cfg_write = w;
		cfg_addr = a;
		tick;
		cfg_valid = 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		cfg_byte_en = be;
		cfg_wdata = d;
		cfg(1'h1, a);
		tick;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		cfg(1'h0, a);
		chk1(cfg_rvalid, 1'h1);
		chk(cfg_rdata, exp);
		tick;
	endtask
	task automatic tgt(input pbcs_space_t s, input logic exp);
		tgt_req = '{1'h1, s, 1'h1, 32'h0000_2000};
		tick;
		tgt_req.valid = 1'h0;
		chk1(tgt_claim, exp);
		chk1(fwd.valid, exp);
		tick;
	endtask
	// start word from mst_addr, word 0x40 is aligned to a four word line
	task automatic mst(input logic w, input logic [15:0] n, input logic [3:0] c, input int a);
		mst_req = '{1'h1, w, mst_addr, n};
		acks_seen = 0;
		tick;
		mst_req.valid = 1'h0;
		chk1(mst_start, 1'h1);
		chk({28'h0, mst_cmd}, {28'h0, c});
		for (int i = 0; i < 40 && burst_stop !== 1'h1; i++)
			tick;
		chk(acks_seen, a);
	endtask

	initial
	begin
		repeat (2) @(posedge ref_clk);
		#1;
		reset = 1'h0;
		tick;
		rd(8'h04, 32'h02a0_0000);
		tgt(PBCS_SPACE_MEM, 1'h0);
		rd(8'h10, 32'h0000_0000);
		wr(8'h04, 4'hf, 32'h00ff_ffff);
		rd(8'h04, 32'h02a0_0156);
		wr(8'h0c, 4'h1, 32'h0000_0004);
		rd(8'h0c, 32'h0000_0004);
		tgt(PBCS_SPACE_MEM, 1'h1);
		tgt(PBCS_SPACE_IO, 1'h0);
		tgt(PBCS_SPACE_SPECIAL, 1'h0);
		tgt(PBCS_SPACE_CONFIG, 1'h0);
		mst(1'h1, 16'h0004, PBCS_CMD_WRITE_INV, 4);
		mst(1'h1, 16'h0003, PBCS_CMD_MEM_WRITE, 3);
		mst_addr = 32'h0000_0104;
		mst(1'h1, 16'h0004, PBCS_CMD_MEM_WRITE, 4);
		mst_addr = 32'h0000_0100;
		slow = 1'h1;
		mst(1'h0, 16'h0008, PBCS_CMD_READ_MULTI, 8);
		slow = 1'h0;
		mst(1'h0, 16'h0004, PBCS_CMD_READ_LINE, 4);
		lat_timer_expired = 1'h1;
		mst(1'h1, 16'h0008, PBCS_CMD_WRITE_INV, 4);
		mst(1'h0, 16'h0008, PBCS_CMD_READ_MULTI, 1);
		lat_timer_expired = 1'h0;
		bad_parity = 1'h1;
		mst(1'h0, 16'h0001, PBCS_CMD_MEM_READ, 1);
		chk1(last_berr, 1'h1);
		chk1(pci_error_irq, 1'h1);
		rd(8'h04, 32'h83a0_0156);
		wr(8'h04, 4'h8, 32'h0000_0000);
		rd(8'h04, 32'h83a0_0156);
		wr(8'h04, 4'h8, 32'h0100_0000);
		rd(8'h04, 32'h82a0_0156);
		chk1(pci_error_irq, 1'h0);
		fatal_error = 1'h1;
		tick;
		chk1(system_error_pin_drive, 1'h1);
		wr(8'h04, 4'hb, 32'h8000_0016);
		repeat (2) tick;
		chk1(system_error_pin_drive, 1'h0);
		fatal_error = 1'h0;
		rd(8'h04, 32'h02a0_0016);
		mst(1'h0, 16'h0001, PBCS_CMD_MEM_READ, 1);
		chk1(last_berr, 1'h0);
		par_err_master_write = 1'h1;
		tick;
		par_err_master_write = 1'h0;
		rd(8'h04, 32'h82a0_0016);
		chk1(pci_error_irq, 1'h0);
		wr(8'h04, 4'h8, 32'h8000_0000);
		rd(8'h04, 32'h02a0_0016);
		par_err_other = 1'h1;
		tick;
		par_err_other = 1'h0;
		rd(8'h04, 32'h82a0_0016);
		chk1(pci_error_irq, 1'h0);
		wr(8'h04, 4'h1, 32'h0000_0000);
		mst_req.valid = 1'h1;
		tick;
		mst_req.valid = 1'h0;
		chk1(mst_refused, 1'h1);
		close_out;
	end
endmodule
